// ### phx_pkg.sv
// package of constants and types for the prefetch hint execution unit
package phx_pkg;

  // ==========================================================================
  // widths
  localparam int ADDR_W = 32;
  localparam int HINT_W = 5;
  localparam int CCA_W  = 3;
  localparam int SEG_W  = 2;

  // ==========================================================================
  // hint ranges and reset values
  localparam logic [4:0]        HINT_LAST_LEGAL = 5'h17;   // 23
  localparam logic [ADDR_W-1:0] ADDR_RST        = 32'h0000_0000;
  localparam logic [CCA_W-1:0]  CCA_RST         = 3'h0;
  localparam logic [HINT_W-1:0] HINT_RST        = 5'h00;

  // ==========================================================================
  // user-accessible kernel segment modes
  localparam logic [SEG_W-1:0] SEG_MODE_A = 2'h1;  // user_mapped_seg_mode_a
  localparam logic [SEG_W-1:0] SEG_MODE_B = 2'h2;  // user_mapped_seg_mode_b
  localparam logic [SEG_W-1:0] SEG_MODE_C = 2'h3;  // user_mapped_seg_mode_c

  // ==========================================================================
  // instruction forms
  typedef enum logic [1:0] {
    PHX_FORM_BASE_OFFSET = 2'b00,  // prefetch_base_offset_form
    PHX_FORM_USER_SEG    = 2'b01,  // prefetch_user_segment_kernel
    PHX_FORM_INDEXED     = 2'b10   // prefetch_indexed_form
  } phx_form_type;

  // ==========================================================================
  // translate-and-issue state machine
  typedef enum logic [1:0] {
    PHX_IDLE  = 2'b00,
    PHX_XLATE = 2'b01,
    PHX_ISSUE = 2'b10
  } phx_state_type;

endpackage : phx_pkg

// ### phx_addr_gen.sv
// effective address generator for both prefetch addressing modes
`timescale 1ns/10ps
module phx_addr_gen
  import phx_pkg::*;
(
  input  wire logic [1:0]        form_in,
  input  wire logic [ADDR_W-1:0] base_in,
  input  wire logic [ADDR_W-1:0] index_in,
  input  wire logic [15:0]       offset_in,
  output logic      [ADDR_W-1:0] vaddr_out
);

  // base plus index, or base plus sign-extended offset
  always_comb begin
    if (form_in == PHX_FORM_INDEXED) begin
      vaddr_out = base_in + index_in;
    end else begin
      vaddr_out = base_in + {{(ADDR_W-16){offset_in[15]}}, offset_in};
    end
  end

endmodule : phx_addr_gen

// ### phx_hint_dec.sv
// hint field decoder shared by all prefetch forms
`timescale 1ns/10ps
module phx_hint_dec
  import phx_pkg::*;
(
  input  wire logic [HINT_W-1:0] hint_in,
  input  wire logic              rel6_in,
  output logic                   reserved_out,
  output logic                   nop_out
);

  // in the newest release 0..23 are legal no-ops and 24..31 reserved
  always_comb begin
    reserved_out = rel6_in && (hint_in > HINT_LAST_LEGAL);
    nop_out      = rel6_in && (hint_in <= HINT_LAST_LEGAL);
  end

endmodule : phx_hint_dec

// ### phx_prefetch_unit.sv
// prefetch instruction execution: decode, fault check, translate, issue
`timescale 1ns/10ps

// Overview of operation
// - Newest release: base-offset form hints 0 to 23 complete as no-ops, never a fault.
// - Newest release: hints 24 to 31 always raise the reserved fault.
// - No TLB or address exception is ever raised by a prefetch.
// - A mapped address without a held TLB translation moves no data.
// - Bus or cache errors on an unlocked line are reported or dropped as a strap selects; on a locked line they are dropped.
// - A prefetch to a locked line leaves that line untouched.
// - Streamed and retained hints are passed on only as advice.
// - The indexed form address is base register plus index register.
// - The indexed form decodes the hint exactly as the offset form.
// - The address is translated as a data load and issued with hint.
// - Indexed form needs an FPU and is reserved in the newest release.
// - Indexed form faults only as unusable, reserved, bus or cache.
// - A misaligned prefetch address never raises an alignment fault.
// - The user-segment form needs cop0 access and a user segment.
module phx_prefetch_unit
  import phx_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              resetn_in,
  // instruction side
  input  wire logic              issue_valid_in,
  input  wire logic [1:0]        form_in,
  input  wire logic [HINT_W-1:0] hint_in,
  input  wire logic [ADDR_W-1:0] base_in,
  input  wire logic [ADDR_W-1:0] index_in,
  input  wire logic [15:0]       offset_in,
  input  wire logic              rel6_in,
  input  wire logic              fpu_present_in,
  input  wire logic              cop1_usable_in,
  input  wire logic              cop0_access_in,
  input  wire logic [SEG_W-1:0]  seg_mode_in,
  input  wire logic              report_mem_err_in,
  // translation
  output logic                   xlate_req_out,
  output logic      [ADDR_W-1:0] xlate_vaddr_out,
  input  wire logic              xlate_done_in,
  input  wire logic              xlate_mapped_in,
  input  wire logic              xlate_tlb_hit_in,
  input  wire logic [ADDR_W-1:0] xlate_paddr_in,
  input  wire logic [CCA_W-1:0]  xlate_cca_in,
  input  wire logic              xlate_addr_err_in,
  // cache side
  output logic                   pf_valid_out,
  output logic      [ADDR_W-1:0] pf_paddr_out,
  output logic      [CCA_W-1:0]  pf_cca_out,
  output logic      [HINT_W-1:0] pf_hint_out,
  input  wire logic              pf_line_locked_in,
  input  wire logic              pf_bus_err_in,
  input  wire logic              pf_cache_err_in,
  // completion
  output logic                   retire_out,
  output logic                   gpr_we_out,
  output logic                   reserved_opcode_fault_out,
  output logic                   cop_unusable_fault_out,
  output logic                   bus_err_fault_out,
  output logic                   cache_err_fault_out,
  output logic                   addr_err_fault_out,
  output logic                   tlb_fault_out,
  output logic                   align_fault_out
);

  // ==========================================================================
  // decode
  logic [ADDR_W-1:0] vaddr;
  logic              hint_reserved;
  logic              hint_nop;
  logic              fault_ri;
  logic              fault_cpu;
  logic              start_ok;

  phx_addr_gen u_addr (
    .form_in   (form_in),
    .base_in   (base_in),
    .index_in  (index_in),
    .offset_in (offset_in),
    .vaddr_out (vaddr)
  );

  // one decoder serves all forms
  phx_hint_dec u_hint (
    .hint_in      (hint_in),
    .rel6_in      (rel6_in),
    .reserved_out (hint_reserved),
    .nop_out      (hint_nop)
  );

  // user-segment form permission check
  function automatic logic seg_user_ok(input logic [SEG_W-1:0] m);
    seg_user_ok = (m == SEG_MODE_A) || (m == SEG_MODE_B) || (m == SEG_MODE_C);
  endfunction : seg_user_ok

  // instruction-level faults, found at issue time
  always_comb begin
    fault_ri  = hint_reserved;
    fault_cpu = 1'b0;
    if (form_in == PHX_FORM_INDEXED) begin
      fault_ri = fault_ri || rel6_in || !fpu_present_in;
      fault_cpu = !fault_ri && !cop1_usable_in;
    end else if (form_in == PHX_FORM_USER_SEG) begin
      fault_cpu = !cop0_access_in;
      fault_ri  = fault_ri || (cop0_access_in && !seg_user_ok(seg_mode_in));
    end else if (form_in != PHX_FORM_BASE_OFFSET) begin
      fault_ri = 1'b1;
    end
    // hints 0..23 in the newest release finish without further action
    start_ok = issue_valid_in && !fault_ri && !fault_cpu &&
               !hint_nop;
  end

  // ==========================================================================
  // state machine
  phx_state_type state_r;
  phx_state_type state_nxt;
  logic [ADDR_W-1:0] vaddr_r;
  logic [HINT_W-1:0] hint_r;
  logic [ADDR_W-1:0] paddr_r;
  logic [CCA_W-1:0]  cca_r;
  logic              issue_ok;

  // a translation is usable only when unmapped or held in the TLB
  assign issue_ok = !xlate_addr_err_in &&
                    (!xlate_mapped_in || xlate_tlb_hit_in);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      PHX_IDLE: begin
        if (start_ok) begin
          state_nxt = PHX_XLATE;
        end
      end
      PHX_XLATE: begin
        if (xlate_done_in) begin
          state_nxt = issue_ok ? PHX_ISSUE : PHX_IDLE;
        end
      end
      PHX_ISSUE: begin
        state_nxt = PHX_IDLE;
      end
      default: begin
        state_nxt = PHX_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= PHX_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // captured request fields
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      vaddr_r <= ADDR_RST;
      hint_r  <= HINT_RST;
    end else if (state_r == PHX_IDLE && start_ok) begin
      vaddr_r <= vaddr;
      hint_r  <= hint_in;
    end
  end

  // captured translation result
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      paddr_r <= ADDR_RST;
      cca_r   <= CCA_RST;
    end else if (state_r == PHX_XLATE && xlate_done_in) begin
      paddr_r <= xlate_paddr_in;
      cca_r   <= xlate_cca_in;
    end
  end

  // ==========================================================================
  // outputs
  // translated as a data load, issued with pa, attribute and hint
  assign xlate_req_out   = (state_r == PHX_XLATE);
  assign xlate_vaddr_out = vaddr_r;
  assign pf_valid_out    = (state_r == PHX_ISSUE);
  assign pf_paddr_out    = paddr_r;
  assign pf_cca_out      = cca_r;
  assign pf_hint_out     = hint_r;

  // retire pulse and fault flags, registered
  logic retire_r;
  logic ri_r;
  logic cpu_r;
  logic bus_r;
  logic cerr_r;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      retire_r <= 1'b0;
      ri_r     <= 1'b0;
      cpu_r    <= 1'b0;
      bus_r    <= 1'b0;
      cerr_r   <= 1'b0;
    end else begin
      retire_r <= (state_r == PHX_IDLE && issue_valid_in && !start_ok) ||
                  (state_r == PHX_XLATE && xlate_done_in && !issue_ok) ||
                  (state_r == PHX_ISSUE);
      ri_r     <= (state_r == PHX_IDLE) && issue_valid_in && fault_ri;
      cpu_r    <= (state_r == PHX_IDLE) && issue_valid_in && fault_cpu;
      // memory-side errors during issue, reported only if strapped on
      bus_r    <= (state_r == PHX_ISSUE) && report_mem_err_in &&
                  pf_bus_err_in && !pf_line_locked_in;
      cerr_r   <= (state_r == PHX_ISSUE) && report_mem_err_in &&
                  pf_cache_err_in && !pf_line_locked_in;
    end
  end

  assign retire_out                = retire_r;
  assign reserved_opcode_fault_out = ri_r;
  assign cop_unusable_fault_out    = cpu_r;
  assign bus_err_fault_out         = bus_r;
  assign cache_err_fault_out       = cerr_r;
  // prefetch never writes a general register and never takes these faults
  assign gpr_we_out      = 1'b0;
  assign addr_err_fault_out = 1'b0;
  assign tlb_fault_out   = 1'b0;
  assign align_fault_out = 1'b0;
  // locked lines: cache honours pf_line_locked_in and takes no action
  // relies on the cache dropping a locked-line request

  // ==========================================================================
  // checks
  sequence s_issue_start;
    state_r == PHX_IDLE && start_ok;
  endsequence

  property p_rsv_hint;
    @(posedge clk_in) disable iff (!resetn_in)
      issue_valid_in && state_r == PHX_IDLE && rel6_in &&
      hint_in > HINT_LAST_LEGAL |=> reserved_opcode_fault_out;
  endproperty
  a_rsv_hint: assert property (p_rsv_hint) else $error("rsv hint");

  property p_nop_hint;
    @(posedge clk_in) disable iff (!resetn_in)
      issue_valid_in && state_r == PHX_IDLE && rel6_in &&
      form_in == PHX_FORM_BASE_OFFSET && hint_in <= HINT_LAST_LEGAL
      |=> retire_out && !reserved_opcode_fault_out;
  endproperty
  a_nop_hint: assert property (p_nop_hint) else $error("nop hint");

  property p_no_addr_fault;
    @(posedge clk_in) disable iff (!resetn_in)
      !addr_err_fault_out && !tlb_fault_out && !align_fault_out;
  endproperty
  a_no_addr_fault: assert property (p_no_addr_fault)
    else $error("address fault");

  property p_tlb_miss;
    @(posedge clk_in) disable iff (!resetn_in)
      state_r == PHX_XLATE && xlate_done_in && xlate_mapped_in &&
      !xlate_tlb_hit_in |=> !pf_valid_out ##1 !pf_valid_out;
  endproperty
  a_tlb_miss: assert property (p_tlb_miss) else $error("tlb miss");

  property p_idx_rel6;
    @(posedge clk_in) disable iff (!resetn_in)
      issue_valid_in && state_r == PHX_IDLE &&
      form_in == PHX_FORM_INDEXED && rel6_in |=> reserved_opcode_fault_out;
  endproperty
  a_idx_rel6: assert property (p_idx_rel6) else $error("idx rel6");

  property p_issue_seq;
    @(posedge clk_in) disable iff (!resetn_in)
      s_issue_start ##1 (xlate_req_out && xlate_done_in && issue_ok)
      |=> pf_valid_out && pf_paddr_out == $past(xlate_paddr_in) ##1 retire_out;
  endproperty
  a_issue_seq: assert property (p_issue_seq) else $error("issue");

  property p_no_gpr;
    @(posedge clk_in) disable iff (!resetn_in)
      retire_out |-> !gpr_we_out;
  endproperty
  a_no_gpr: assert property (p_no_gpr) else $error("gpr write");

  property p_idx_addr;
    @(posedge clk_in) disable iff (!resetn_in)
      s_issue_start and form_in == PHX_FORM_INDEXED
      |=> xlate_vaddr_out == $past(base_in) + $past(index_in);
  endproperty
  a_idx_addr: assert property (p_idx_addr) else $error("idx addr");

  property p_user_seg;
    @(posedge clk_in) disable iff (!resetn_in)
      issue_valid_in && state_r == PHX_IDLE &&
      form_in == PHX_FORM_USER_SEG && !cop0_access_in
      |=> cop_unusable_fault_out && !xlate_req_out;
  endproperty
  a_user_seg: assert property (p_user_seg) else $error("user seg");

  property p_err_supp;
    @(posedge clk_in) disable iff (!resetn_in)
      pf_valid_out && !report_mem_err_in |=> !bus_err_fault_out &&
      !cache_err_fault_out;
  endproperty
  a_err_supp: assert property (p_err_supp) else $error("err supp");

endmodule : phx_prefetch_unit

// ### phx_mem_model.sv
// translation and cache responder that faces the prefetch unit
`timescale 1ns/10ps
module phx_mem_model
  import phx_pkg::*;
#(
  parameter logic [ADDR_W-1:0] PA_MASK = 32'h4000_0000
) (
  input  wire logic              clk_in,
  input  wire logic              resetn_in,
  input  wire logic              req_in,
  input  wire logic [ADDR_W-1:0] vaddr_in,
  input  wire logic              pf_in,
  input  wire logic [3:0]        delay_in,
  input  wire logic              mapped_in,
  input  wire logic              hit_in,
  input  wire logic              aerr_in,
  input  wire logic [CCA_W-1:0]  cca_in,
  input  wire logic              lock_in,
  input  wire logic              bus_in,
  input  wire logic              cerr_in,
  output logic                   done_out,
  output logic                   mapped_out,
  output logic                   hit_out,
  output logic      [ADDR_W-1:0] paddr_out,
  output logic      [CCA_W-1:0]  cca_out,
  output logic                   aerr_out,
  output logic                   lock_out,
  output logic                   bus_out,
  output logic                   cerr_out
);
  logic [3:0]        wait_r;
  logic [ADDR_W-1:0] last_r;

  // ==========================================================================
  // translation
  // count cycles of a pending lookup so slow answers can be modelled
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) wait_r <= 4'h0;
    else if (!req_in || done_out) wait_r <= 4'h0;
    else wait_r <= wait_r + 4'h1;
  end
  // remember the last address so idle cycles show its inverse
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) last_r <= 32'h0000_0000;
    else if (done_out) last_r <= paddr_out;
  end
  // answer as a data load lookup; qualifiers are scrambled outside done
  assign done_out   = req_in && (wait_r == delay_in);
  assign paddr_out  = done_out ? (vaddr_in ^ PA_MASK) : ~last_r;
  assign cca_out    = done_out ? cca_in : ~cca_in;
  assign mapped_out = done_out ? mapped_in : ~mapped_in;
  assign hit_out    = done_out ? hit_in : ~hit_in;
  assign aerr_out   = done_out ? aerr_in : ~aerr_in;

  // ==========================================================================
  // cache status, valid only in the request cycle
  assign lock_out = pf_in & lock_in;
  assign bus_out  = pf_in & bus_in;
  assign cerr_out = pf_in & cerr_in;
endmodule : phx_mem_model

// ### test_prefetch_hint_execution.sv
// self-checking bench for the prefetch unit
`timescale 1ns/10ps
module test_prefetch_hint_execution
  import phx_pkg::*;
;
  localparam logic [ADDR_W-1:0] PA_MASK = 32'h4000_0000;
  logic clk_in = 0, resetn_in = 0, issue_valid_in = 0, rel6_in = 0;
  logic fpu_present_in = 1, cop1_usable_in = 1, cop0_access_in = 1;
  logic report_mem_err_in = 1;
  logic [1:0] form_in = 0;
  logic [HINT_W-1:0] hint_in = 0;
  logic [ADDR_W-1:0] base_in = 0, index_in = 0;
  logic [15:0] offset_in = 0;
  logic [SEG_W-1:0] seg_mode_in = SEG_MODE_A;
  logic [3:0] cfg_dly = 0;
  logic cfg_map = 0, cfg_hit = 1, cfg_aerr = 0, cfg_lock = 0;
  logic cfg_bus = 0, cfg_cerr = 0;
  logic [CCA_W-1:0] cfg_cca = 3'h5;
  logic xlate_req_out, xlate_done_in, xlate_mapped_in, xlate_tlb_hit_in;
  logic xlate_addr_err_in, pf_valid_out, pf_line_locked_in;
  logic pf_bus_err_in, pf_cache_err_in, retire_out, gpr_we_out;
  logic reserved_opcode_fault_out, cop_unusable_fault_out;
  logic bus_err_fault_out, cache_err_fault_out, addr_err_fault_out;
  logic tlb_fault_out, align_fault_out;
  logic [ADDR_W-1:0] xlate_vaddr_out, xlate_paddr_in, pf_paddr_out, got_pa;
  logic [CCA_W-1:0] xlate_cca_in, pf_cca_out, got_cca;
  logic [HINT_W-1:0] pf_hint_out, got_hint;
  logic [4:0] seen_r = 0;  // pf, reserved, unusable, bus, cache
  logic [3:0] bad_r = 0;   // tlb, address, alignment, register write
  logic ret_r = 0;
  int bad_count = 0, n_checks = 0;

  // ==========================================================================
  // clock, design and far side
  always #10 clk_in = ~clk_in;
  phx_prefetch_unit dut (.*);
  phx_mem_model #(.PA_MASK(PA_MASK)) mem (.clk_in(clk_in),
    .resetn_in(resetn_in), .req_in(xlate_req_out),
    .vaddr_in(xlate_vaddr_out), .pf_in(pf_valid_out), .delay_in(cfg_dly),
    .mapped_in(cfg_map), .hit_in(cfg_hit), .aerr_in(cfg_aerr),
    .cca_in(cfg_cca), .lock_in(cfg_lock), .bus_in(cfg_bus),
    .cerr_in(cfg_cerr), .done_out(xlate_done_in),
    .mapped_out(xlate_mapped_in), .hit_out(xlate_tlb_hit_in),
    .paddr_out(xlate_paddr_in), .cca_out(xlate_cca_in),
    .aerr_out(xlate_addr_err_in), .lock_out(pf_line_locked_in),
    .bus_out(pf_bus_err_in), .cerr_out(pf_cache_err_in));

  // collect one-cycle pulses of the current operation
  always @(posedge clk_in) begin
    if (retire_out) ret_r <= 1'b1;
    seen_r <= seen_r | {pf_valid_out, reserved_opcode_fault_out,
      cop_unusable_fault_out, bus_err_fault_out, cache_err_fault_out};
    bad_r <= bad_r | {tlb_fault_out, addr_err_fault_out, align_fault_out,
      gpr_we_out};
    if (pf_valid_out) begin
      got_pa <= pf_paddr_out;
      got_cca <= pf_cca_out;
      got_hint <= pf_hint_out;
    end
  end

  // ==========================================================================
  // shared tasks
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  task automatic cmp(input logic [ADDR_W-1:0] got,
      input logic [ADDR_W-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // issue one prefetch, wait for retire, judge the pulses seen
  task automatic op(input logic [1:0] f, input logic [HINT_W-1:0] h,
      input logic [ADDR_W-1:0] b, input logic [ADDR_W-1:0] x,
      input logic [15:0] o, input logic [4:0] exp, input logic [ADDR_W-1:0] va);
    int n;
    seen_r = 5'h00;
    bad_r = 4'h0;
    ret_r = 1'b0;
    form_in = f;
    hint_in = h;
    base_in = b;
    index_in = x;
    offset_in = o;
    issue_valid_in = 1'b1;
    @(posedge clk_in);
    #1 issue_valid_in = 1'b0;
    n = 0;
    while (!ret_r && n < 40) begin
      @(posedge clk_in);
      #1 n++;
    end
    if (!ret_r) begin
      bad_count++;
      $display("[FAIL] t=%0t no retire", $time);
      end_sim;
    end
    cmp(32'(seen_r), 32'(exp));
    cmp(32'(bad_r), 32'h0);
    if (exp[4]) begin
      cmp(got_pa, va ^ PA_MASK);
      cmp(32'(got_hint), 32'(h));
      cmp(32'(got_cca), 32'(cfg_cca));
    end
  endtask : op

  // ==========================================================================
  // scenarios
  task automatic t_rel6;
    rel6_in = 1'b1;
    for (int h = 0; h < 32; h++)
      op(2'h0, 5'(h), 32'h10, 0, 0, (h > 23) ? 5'h08 : 5'h00, 0);
    op(2'h2, 5'h01, 32'h10, 32'h4, 0, 5'h08, 0);
    rel6_in = 1'b0;
    $display("rel6 hints done");
  endtask : t_rel6

  task automatic t_forms;
    for (int h = 0; h < 8; h++) begin
      op(2'h0, 5'(h), 32'h1000_0003, 0, 16'hfffc, 5'h10, 32'h0fff_ffff);
      op(2'h2, 5'(h), 32'h2000_0000, 32'h104, 0, 5'h10, 32'h2000_0104);
    end
    cfg_dly = 4'h3;
    op(2'h2, 5'h04, 32'hffff_fff0, 32'h13, 0, 5'h10, 32'h0000_0003);
    cfg_dly = 4'h0;
    fpu_present_in = 1'b0;
    op(2'h2, 5'h00, 0, 0, 0, 5'h08, 0);
    fpu_present_in = 1'b1;
    cop1_usable_in = 1'b0;
    op(2'h2, 5'h00, 0, 0, 0, 5'h04, 0);
    cop1_usable_in = 1'b1;
    op(2'h3, 5'h00, 0, 0, 0, 5'h08, 0);
    $display("address forms done");
  endtask : t_forms

  task automatic t_tlb;
    cfg_map = 1'b1;
    cfg_hit = 1'b0;
    cfg_dly = 4'h5;
    op(2'h0, 5'h00, 32'h0040_0001, 0, 0, 5'h00, 0);
    cfg_map = 1'b0;
    cfg_hit = 1'b1;
    cfg_aerr = 1'b1;
    op(2'h0, 5'h01, 32'hffff_ffff, 0, 16'h0001, 5'h00, 0);
    cfg_aerr = 1'b0;
    cfg_dly = 4'h0;
    $display("tlb and address done");
  endtask : t_tlb

  task automatic t_mem_err;
    cfg_bus = 1'b1;
    op(2'h0, 5'h00, 32'h100, 0, 0, 5'h12, 32'h100);
    cfg_lock = 1'b1;
    op(2'h0, 5'h00, 32'h100, 0, 0, 5'h10, 32'h100);
    cfg_lock = 1'b0;
    report_mem_err_in = 1'b0;
    op(2'h0, 5'h00, 32'h100, 0, 0, 5'h10, 32'h100);
    report_mem_err_in = 1'b1;
    cfg_bus = 1'b0;
    cfg_cerr = 1'b1;
    op(2'h2, 5'h00, 32'h100, 32'h8, 0, 5'h11, 32'h108);
    cfg_cerr = 1'b0;
    $display("memory errors done");
  endtask : t_mem_err

  task automatic t_user_seg;
    cop0_access_in = 1'b0;
    op(2'h1, 5'h00, 32'h200, 0, 0, 5'h04, 0);
    cop0_access_in = 1'b1;
    seg_mode_in = 2'h0;
    op(2'h1, 5'h00, 32'h200, 0, 0, 5'h08, 0);
    for (int s = 1; s < 4; s++) begin
      seg_mode_in = 2'(s);
      op(2'h1, 5'h03, 32'h200, 0, 16'h0010, 5'h10, 32'h210);
    end
    $display("user segment done");
  endtask : t_user_seg

  // ==========================================================================
  // main sequence
  initial begin
    repeat (16) @(posedge clk_in);
    #1 resetn_in = 1'b1;
    @(posedge clk_in);
    #1;
    t_rel6;
    t_forms;
    t_tlb;
    t_mem_err;
    t_user_seg;
    end_sim;
  end
endmodule : test_prefetch_hint_execution
